// file: core/exc_defs.svh
`ifndef EXC_DEFS_SVH
`define EXC_DEFS_SVH

// Reset sequence and interrupt timing, in CLK cycles
`define RESET_SEQ_CYCLES     4'h7
`define NMI_BLIND_CYCLES     4'h2
`define NMI_EARLY_CYCLES     4'h9
// Vector numbers and addresses
`define NMI_TYPE             8'h02
`define RESET_START_ADDR     20'hFFFF0
`define VECTOR_SHIFT         2
// Last T state of a four-T-state bus cycle, counted from 0
`define T_STATES             2'h3
// Cycle status codes, cycle_status_2..0
`define STATUS_ACK           3'h0
`define STATUS_HALT          3'h3
`define STATUS_PASSIVE       3'h7

`endif

// file: core/exc_pkg.sv
package exc_pkg;
   typedef enum logic [2:0] {
      ST_RESET,
      ST_INIT,
      ST_RUN,
      ST_ACK1,
      ST_ACK2,
      ST_VECTOR,
      ST_HALT
   } exc_state_t;
endpackage

// file: core/nmi_edge_latch.sv
`timescale 1ns/1ns
`include "exc_defs.svh"

// Holds a pending non-maskable request from a rising edge until it is taken.
module nmi_edge_latch
(
   input  wire logic clk,
   input  wire logic rst,
   input  wire logic nmi_in,
   input  wire logic armed,
   input  wire logic take,
   output logic      pending
);
   typedef struct packed {
      logic prev;
      logic pend;
   } latch_st_t;

   latch_st_t s_r;
   latch_st_t s_nxt;
   logic      rise;

   assign rise    = nmi_in && !s_r.prev;
   assign pending = s_r.pend;

   always_comb
   begin
      s_nxt      = s_r;
      s_nxt.prev = nmi_in;
      if (take)
      begin
         s_nxt.pend = 1'b0;
      end
      // latch an armed rising edge; an edge in the same cycle as take wins
      if (rise && armed)
      begin
         s_nxt.pend = 1'b1;
      end
   end

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         s_r <= '0;
      end
      else
      begin
         s_r <= s_nxt;
      end
   end
endmodule

// file: core/exc_unit.sv
`timescale 1ns/1ns
`include "exc_defs.svh"

// Behaviour
// - While reset is high all operation stops and the unit stays dormant.
// - Reset fall starts a seven-clock sequence, then fetch at FFFF0.
// - Non-maskable input ignored before second clock after reset ends.
// - Vector table of 256 four-byte entries at 0 to 3FF, by type.
// - Response saves flags, code segment and pointer; return restores them.
// - Non-maskable input is rising-edge, beats maskable, yields type 2.
// - Non-maskable edge latched, serviced at instruction or block-move end.
// - Another edge after service start causes another response.
// - Maskable request is level, gated by enable flag, sampled at each instruction boundary.
// - Enable flag cleared on response; pushed flags show previous value.
// - Maskable response uses two acknowledge cycles; lock from T2 to T2 in maximum mode.
// - Hold request during acknowledge waits until second cycle ends.
// - Controller supplies type byte in cycle two; pointer is type times four.
// - Halt in minimum mode gives one latch pulse without strobes.
// - Hold during halt does not end it; halt indication reissued after.
// - Halt left only on non-maskable, enabled maskable request, or reset.
// - Lock low the clock after prefix decode, high after last bus cycle.
// - Request/grant during lock is recorded and granted after lock ends.
// - Maximum mode halt status is low, high, high on the status lines.
module exc_unit
(
   input  wire logic        CLK,
   input  wire logic        RST,
   input  wire logic        NMI,
   input  wire logic        MASKABLE_IRQ_REQ,
   input  wire logic        MODE_STRAP,
   input  wire logic        INSTR_BOUNDARY,
   input  wire logic        HALT_INSTR,
   input  wire logic        LOCK_PREFIX,
   input  wire logic        LOCKED_LAST_CYCLE,
   input  wire logic        HOLD_REQ,
   input  wire logic        REQUEST_GRANT_PIN,
   input  wire logic        INTERRUPT_RETURN_INSTR,
   input  wire logic        SET_IF,
   input  wire logic        CLR_IF,
   input  wire logic [7:0]  DATA_IN,
   output logic             RUN_EN,
   output logic             START_FETCH,
   output logic [19:0]      FETCH_ADDR,
   output logic             IRQ_ACK_STROBE_N,
   output logic             LOCK_N,
   output logic             ALE,
   output logic [2:0]       CYCLE_STATUS,
   output logic             HOLD_ACK,
   output logic             GRANT,
   output logic             SERVICE_START,
   output logic [7:0]       VECTOR_TYPE,
   output logic [9:0]       VECTOR_PTR,
   output logic             PUSH_CONTEXT,
   output logic             POP_CONTEXT,
   output logic             FLAGS_IF_SAVED,
   output logic             IF_FLAG,
   output logic             HALTED
);
   // ------------------------------------------------------------
   // State
   // ------------------------------------------------------------
   typedef struct packed {
      exc_pkg::exc_state_t st;
      logic [3:0]  cnt;
      logic [1:0]  tst;
      logic        armed;
      logic        early;
      logic        if_f;
      logic        lock_pre;
      logic        rqgt_pend;
      logic        halt_shown;
      logic        max_mode;
      logic        run_en;
      logic        start_fetch;
      logic [19:0] fetch_addr;
      logic        ack_n;
      logic        lock_n;
      logic        ale;
      logic [2:0]  status;
      logic        hold_ack;
      logic        grant;
      logic        svc;
      logic [7:0]  vtype;
      logic [9:0]  vptr;
      logic        push;
      logic        pop;
      logic        saved_if;
      logic        halted;
   } exc_st_t;

   exc_st_t s_r;
   exc_st_t s_nxt;
   logic    nmi_pend;
   logic    nmi_take;
   logic    in_ack;

   // Pointer into the vector table: type times four
   function automatic logic [9:0] vec_ptr(input logic [7:0] t);
      vec_ptr = {t, 2'b00};
   endfunction

   assign in_ack = (s_r.st == exc_pkg::ST_ACK1) || (s_r.st == exc_pkg::ST_ACK2);

   // edges only latched once the blind window has passed
   nmi_edge_latch u_nmi
   (
      .clk     (CLK),
      .rst     (RST),
      .nmi_in  (NMI),
      .armed   (s_r.armed),
      .take    (nmi_take),
      .pending (nmi_pend)
   );

   // ------------------------------------------------------------
   // Next state
   // ------------------------------------------------------------
   always_comb
   begin
      s_nxt             = s_r;
      nmi_take          = 1'b0;
      s_nxt.start_fetch = 1'b0;
      s_nxt.ale         = 1'b0;
      s_nxt.svc         = 1'b0;
      s_nxt.push        = 1'b0;
      s_nxt.pop         = 1'b0;
      s_nxt.tst         = s_r.tst + 2'h1;
      if (SET_IF)
      begin
         s_nxt.if_f = 1'b1;
      end
      if (CLR_IF)
      begin
         s_nxt.if_f = 1'b0;
      end
      if (INTERRUPT_RETURN_INSTR && s_r.run_en)
      begin
         s_nxt.pop  = 1'b1;
         s_nxt.if_f = s_r.saved_if;
      end
      // lock follows the prefix, ends with its last cycle
      if (LOCK_PREFIX && s_r.run_en)
      begin
         s_nxt.lock_pre = 1'b1;
      end
      else if (LOCKED_LAST_CYCLE)
      begin
         s_nxt.lock_pre = 1'b0;
      end
      // record request/grant while locked, grant after release
      if (REQUEST_GRANT_PIN)
      begin
         s_nxt.rqgt_pend = 1'b1;
      end
      s_nxt.grant = 1'b0;
      if (s_r.rqgt_pend && s_r.lock_n && !s_r.lock_pre && !in_ack)
      begin
         s_nxt.grant     = 1'b1;
         s_nxt.rqgt_pend = REQUEST_GRANT_PIN;
      end
      s_nxt.hold_ack = HOLD_REQ && !in_ack && s_r.lock_n && s_r.st != exc_pkg::ST_RESET
                       && s_r.st != exc_pkg::ST_INIT;
      s_nxt.lock_n = !(s_r.lock_pre || (LOCK_PREFIX && s_r.run_en));
      if (s_r.cnt != 4'h0)
      begin
         s_nxt.cnt = s_r.cnt - 4'h1;
      end
      case (s_r.st)
         exc_pkg::ST_RESET:
         begin
            s_nxt.st  = exc_pkg::ST_INIT;
            s_nxt.cnt = `RESET_SEQ_CYCLES;
            s_nxt.max_mode = !MODE_STRAP;
         end
         exc_pkg::ST_INIT:
         begin
            if (s_r.cnt == 4'h1)
            begin
               s_nxt.st          = exc_pkg::ST_RUN;
               s_nxt.run_en      = 1'b1;
               s_nxt.start_fetch = 1'b1;
               s_nxt.fetch_addr  = `RESET_START_ADDR;
            end
         end
         exc_pkg::ST_RUN:
         begin
            if (INSTR_BOUNDARY && nmi_pend)
            begin
               nmi_take         = 1'b1;
               s_nxt.svc        = 1'b1;
               s_nxt.vtype      = `NMI_TYPE;
               s_nxt.vptr       = vec_ptr(`NMI_TYPE);
               s_nxt.push       = 1'b1;
               s_nxt.saved_if   = s_r.if_f;
               s_nxt.if_f       = 1'b0;
            end
            else if (INSTR_BOUNDARY && MASKABLE_IRQ_REQ && s_r.if_f)
            begin
               s_nxt.st       = exc_pkg::ST_ACK1;
               s_nxt.run_en   = 1'b0;
               s_nxt.tst      = 2'h0;
               s_nxt.saved_if = s_r.if_f;
               s_nxt.if_f     = 1'b0;
               s_nxt.ale      = 1'b1;
               s_nxt.status   = s_r.max_mode ? `STATUS_ACK : `STATUS_PASSIVE;
            end
            else if (HALT_INSTR)
            begin
               s_nxt.st         = exc_pkg::ST_HALT;
               s_nxt.run_en     = 1'b0;
               s_nxt.halt_shown = 1'b0;
            end
         end
         // two back-to-back acknowledge cycles, lock T2 to T2 in maximum mode
         exc_pkg::ST_ACK1:
         begin
            s_nxt.ack_n = !(s_r.tst == 2'h0 || s_r.tst == 2'h1);
            if (s_r.tst == 2'h0 && s_r.max_mode)
            begin
               s_nxt.lock_n = 1'b0;
            end
            else if (s_r.max_mode)
            begin
               s_nxt.lock_n = 1'b0;
            end
            if (s_r.tst == `T_STATES)
            begin
               s_nxt.st  = exc_pkg::ST_ACK2;
               s_nxt.ale = 1'b1;
            end
         end
         exc_pkg::ST_ACK2:
         begin
            s_nxt.ack_n = !(s_r.tst == 2'h0 || s_r.tst == 2'h1);
            s_nxt.lock_n = !(s_r.max_mode && s_r.tst == 2'h3);
            // type byte read in second cycle, times four
            if (s_r.tst == 2'h2)
            begin
               s_nxt.vtype = DATA_IN;
               s_nxt.vptr  = vec_ptr(DATA_IN);
            end
            if (s_r.tst == `T_STATES)
            begin
               s_nxt.st     = exc_pkg::ST_VECTOR;
               s_nxt.lock_n = 1'b1;
               s_nxt.status = `STATUS_PASSIVE;
            end
         end
         exc_pkg::ST_VECTOR:
         begin
            s_nxt.st     = exc_pkg::ST_RUN;
            s_nxt.run_en = 1'b1;
            s_nxt.svc    = 1'b1;
            s_nxt.push   = 1'b1;
         end
         exc_pkg::ST_HALT:
         begin
            if (!s_r.halt_shown && !HOLD_REQ)
            begin
               s_nxt.halt_shown = 1'b1;
               s_nxt.ale    = !s_r.max_mode;
               s_nxt.status = s_r.max_mode ? `STATUS_HALT : `STATUS_PASSIVE;
            end
            else if (HOLD_REQ)
            begin
               s_nxt.halt_shown = 1'b0;
               s_nxt.status     = `STATUS_PASSIVE;
            end
            else
            begin
               s_nxt.status = `STATUS_PASSIVE;
            end
            if (nmi_pend || (MASKABLE_IRQ_REQ && s_r.if_f))
            begin
               s_nxt.st     = exc_pkg::ST_RUN;
               s_nxt.run_en = 1'b1;
               s_nxt.status = `STATUS_PASSIVE;
            end
         end
         default:
         begin
            s_nxt.st = exc_pkg::ST_RESET;
         end
      endcase
      // blind two clocks, early flag held only through init
      if (s_r.st == exc_pkg::ST_INIT && s_r.cnt == `RESET_SEQ_CYCLES - `NMI_BLIND_CYCLES + 4'h1)
      begin
         s_nxt.armed = 1'b1;
      end
      s_nxt.early = (s_r.st == exc_pkg::ST_INIT) || (s_r.st == exc_pkg::ST_RUN &&
                    s_r.early && s_r.cnt != 4'h0);
      // Halt flag registered so the pin does not hang off the state decode
      s_nxt.halted = (s_nxt.st == exc_pkg::ST_HALT);
   end

   // ------------------------------------------------------------
   // Registers
   // ------------------------------------------------------------
   // reset holds everything dormant
   always_ff @(posedge CLK or posedge RST)
   begin
      if (RST)
      begin
         s_r        <= '0;
         s_r.st     <= exc_pkg::ST_RESET;
         s_r.ack_n  <= 1'b1;
         s_r.lock_n <= 1'b1;
         s_r.status <= `STATUS_PASSIVE;
      end
      else
      begin
         s_r <= s_nxt;
      end
   end

   assign RUN_EN           = s_r.run_en;
   assign START_FETCH      = s_r.start_fetch;
   assign FETCH_ADDR       = s_r.fetch_addr;
   assign IRQ_ACK_STROBE_N = s_r.ack_n;
   assign LOCK_N           = s_r.lock_n;
   assign ALE              = s_r.ale;
   assign CYCLE_STATUS     = s_r.status;
   assign HOLD_ACK         = s_r.hold_ack;
   assign GRANT            = s_r.grant;
   assign SERVICE_START    = s_r.svc;
   assign VECTOR_TYPE      = s_r.vtype;
   assign VECTOR_PTR       = s_r.vptr;
   assign PUSH_CONTEXT     = s_r.push;
   assign POP_CONTEXT      = s_r.pop;
   assign FLAGS_IF_SAVED   = s_r.saved_if;
   assign IF_FLAG          = s_r.if_f;
   assign HALTED           = s_r.halted;

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   property p_vec;
      @(posedge CLK) disable iff (RST) SERVICE_START |-> VECTOR_PTR == {VECTOR_TYPE, 2'b00};
   endproperty
   a_vec: assert property (p_vec) else $error("vector pointer not type times four");

   property p_run_after_reset;
      @(posedge CLK) $fell(RST) |-> !RUN_EN [*8] ##1 RUN_EN && FETCH_ADDR == 20'hFFFF0;
   endproperty
   a_run_after_reset: assert property (p_run_after_reset) else $error("reset sequence length wrong");

   property p_if_clear;
      @(posedge CLK) disable iff (RST) PUSH_CONTEXT && !POP_CONTEXT |-> !IF_FLAG;
   endproperty
   a_if_clear: assert property (p_if_clear) else $error("enable flag not cleared on response");

   property p_no_hold_ack;
      @(posedge CLK) disable iff (RST) !IRQ_ACK_STROBE_N |-> !HOLD_ACK;
   endproperty
   a_no_hold_ack: assert property (p_no_hold_ack) else $error("hold granted in acknowledge");

   property p_grant_lock;
      @(posedge CLK) disable iff (RST) GRANT |-> $past(LOCK_N);
   endproperty
   a_grant_lock: assert property (p_grant_lock) else $error("grant while locked");

   property p_halt_exit;
      @(posedge CLK) disable iff (RST) HALTED && !IF_FLAG && !u_nmi.pending |=> HALTED;
   endproperty
   a_halt_exit: assert property (p_halt_exit) else $error("halt left without cause");

   property p_nmi_type;
      @(posedge CLK) disable iff (RST) $rose(SERVICE_START) && s_r.st == exc_pkg::ST_RUN
         && $past(s_r.st) == exc_pkg::ST_RUN |-> VECTOR_TYPE == 8'h02;
   endproperty
   a_nmi_type: assert property (p_nmi_type) else $error("non-maskable type not 2");

   property p_lock_prefix;
      @(posedge CLK) disable iff (RST) LOCK_PREFIX && RUN_EN |=> !LOCK_N;
   endproperty
   a_lock_prefix: assert property (p_lock_prefix) else $error("lock not asserted after prefix");

   property p_halt_status;
      @(posedge CLK) disable iff (RST) CYCLE_STATUS == 3'h3 |-> HALTED;
   endproperty
   a_halt_status: assert property (p_halt_status) else $error("halt status outside halt");

   c_ack:  cover property (@(posedge CLK) disable iff (RST) $fell(IRQ_ACK_STROBE_N));
   c_halt: cover property (@(posedge CLK) disable iff (RST) $rose(HALTED));
   c_nmi:  cover property (@(posedge CLK) disable iff (RST) SERVICE_START && VECTOR_TYPE == 8'h02);
   c_grnt: cover property (@(posedge CLK) disable iff (RST) GRANT);
endmodule

// file: sim/irq_ctrl_model.sv
`timescale 1ns/1ns
// ---------------------------------------------
// Interrupt controller on the acknowledge side
// ---------------------------------------------
module irq_ctrl_model
(
   input  wire logic       clk,
   input  wire logic       want,
   input  wire logic       slow,
   input  wire logic [7:0] type_byte,
   input  wire logic       ack_n,
   output logic            irq_req,
   output logic [7:0]      data_out
);
   logic       want_d;
   logic       ack_d;
   logic [1:0] falls;
   logic [2:0] drive_cnt;

   initial
   begin
      want_d = 1'h0;
      ack_d = 1'h1;
      falls = 2'h0;
      drive_cnt = 3'h0;
      irq_req = 1'h0;
      data_out = 8'hA5;
   end

   always @(posedge clk)
   begin
      want_d <= want;
      ack_d <= ack_n;
      if (want && !want_d)
      begin
         irq_req <= 1'h1;
         falls <= 2'h0;
      end
      else if (!want)
         irq_req <= 1'h0;
      else if (ack_d && !ack_n)
      begin
         falls <= falls + 2'h1;
         if (!slow || falls == 2'h1)
            irq_req <= 1'h0;
      end
      if (want && ack_d && !ack_n && falls == 2'h1)
      begin
         drive_cnt <= 3'h6;
         data_out <= type_byte;
      end
      else if (drive_cnt != 3'h0)
         drive_cnt <= drive_cnt - 3'h1;
      else
         data_out <= ~data_out;   // Released bus toggles each clock, so the stale type shows again every other clock
   end
endmodule

// file: sim/cpu_reset_interrupt_halt_lock_tb_top.sv
`timescale 1ns/1ns
`include "exc_defs.svh"
module cpu_reset_interrupt_halt_lock_tb_top;
   logic        clk, rst, nmi, want, slow, mode, bnd, halt_i, lock_p, lock_last;
   logic        hold_req, rg_pin, interrupt_return_instr, set_if, clr_if, irq_req;
   logic        run_en, start_fetch, ack_n, lock_n, ale, hold_ack, grant, svc;
   logic        push, pop, if_saved, if_flag, halted;
   logic [7:0]  tbyte, data, vtype, e;
   logic [9:0]  vptr;
   logic [2:0]  cstat;
   logic [19:0] fetch_addr;
   logic [31:0] r;
   logic [7:0]  exp_q[$];
   int          fail_count, num_checks, seed, n;

   exc_unit u_dut (.CLK(clk), .RST(rst), .NMI(nmi), .MASKABLE_IRQ_REQ(irq_req),
      .MODE_STRAP(mode), .INSTR_BOUNDARY(bnd), .HALT_INSTR(halt_i), .LOCK_PREFIX(lock_p),
      .LOCKED_LAST_CYCLE(lock_last), .HOLD_REQ(hold_req), .REQUEST_GRANT_PIN(rg_pin),
      .INTERRUPT_RETURN_INSTR(interrupt_return_instr), .SET_IF(set_if), .CLR_IF(clr_if), .DATA_IN(data),
      .RUN_EN(run_en), .START_FETCH(start_fetch), .FETCH_ADDR(fetch_addr),
      .IRQ_ACK_STROBE_N(ack_n), .LOCK_N(lock_n), .ALE(ale), .CYCLE_STATUS(cstat),
      .HOLD_ACK(hold_ack), .GRANT(grant), .SERVICE_START(svc), .VECTOR_TYPE(vtype),
      .VECTOR_PTR(vptr), .PUSH_CONTEXT(push), .POP_CONTEXT(pop),
      .FLAGS_IF_SAVED(if_saved), .IF_FLAG(if_flag), .HALTED(halted));

   irq_ctrl_model u_pic (.clk(clk), .want(want), .slow(slow), .type_byte(tbyte),
      .ack_n(ack_n), .irq_req(irq_req), .data_out(data));

   initial
   begin
      clk = 1'h0;
      forever #4 clk = ~clk;
   end

   // ---------------
   // Shared tasks
   // ---------------
   task automatic step();
      @(negedge clk);
   endtask

   task automatic check(input string nm, input logic [19:0] ex, input logic [19:0] g);
      num_checks++;
      if (g !== ex)
      begin
         fail_count++;
         $display("CHECK FAILED %s expected %0h seen %0h", nm, ex, g);
      end
   endtask

   task automatic report_and_stop();
      if (fail_count == 0 && num_checks > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask

   task automatic pulse(input int s);
      {bnd, halt_i, lock_p, lock_last, rg_pin, interrupt_return_instr, set_if, clr_if} = 8'h80 >> s;
      step();
      {bnd, halt_i, lock_p, lock_last, rg_pin, interrupt_return_instr, set_if, clr_if} = 8'h00;
   endtask

   function automatic logic sig(input int s);
      case (s)
         0: sig = svc;
         1: sig = grant;
         2: sig = hold_ack;
         3: sig = pop;
         default: sig = (cstat === `STATUS_HALT);
      endcase
   endfunction

   task automatic wait_hi(input int s, input int lim);
      int k;
      k = 0;
      while (sig(s) !== 1'h1 && k < lim)
      begin
         step();
         k++;
      end
      if (k >= lim)
      begin
         check("wait bound", 20'h0, 20'h1);
         report_and_stop();
      end
   endtask

   task automatic count_ale(output int c);
      c = 0;
      repeat (10)
      begin
         step();
         c += ale;
         check("no ack strobe", 1, ack_n);
      end
   endtask

   task automatic do_reset(input logic m);
      rst = 1'h1;
      mode = m;
      repeat (6) step();
      check("lock_n in reset", 1, lock_n);
      check("ack_n in reset", 1, ack_n);
      check("status in reset", `STATUS_PASSIVE, cstat);
      check("run_en in reset", 0, run_en);
      nmi = 1'h1;
      rst = 1'h0;
      n = 0;
      while (start_fetch !== 1'h1 && n < 20)
      begin
         step();
         n++;
         if (n == 2)
            nmi = 1'h0;
      end
      check("fetch edge", `RESET_SEQ_CYCLES + 4'h1, n);
      check("fetch addr", `RESET_START_ADDR, fetch_addr);
      check("run_en", 1, run_en);
      pulse(0);
      pulse(0);
   endtask

   task automatic irq(input logic ie, input logic s, input logic [7:0] t);
      int acks;
      logic lk;
      acks = 0;
      lk = 1'h0;
      tbyte = t;
      slow = s;
      want = 1'h1;
      pulse(ie ? 6 : 7);
      check("if flag", ie, if_flag);
      if (ie)
         exp_q.push_back(t);
      pulse(0);
      // Hold asked only once the take is made, so a hold ack seen during the acknowledge cycles is a leak
      hold_req = 1'h1;
      n = 0;
      while (ie && svc !== 1'h1 && n < 30)
      begin
         if (acks < 4 || !ack_n)
            check("hold in ack", 0, hold_ack);
         acks += !ack_n;
         lk |= !lock_n;
         step();
         n++;
      end
      if (ie)
      begin
         check("ack cycles", 4, acks);
         check("lock in ack", !mode, lk);
         check("if cleared", 0, if_flag);
         check("if saved", 1, if_saved);
         wait_hi(2, 10);
      end
      else
      begin
         repeat (12) step();
         check("masked ack", 1, ack_n);
      end
      hold_req = 1'h0;
      want = 1'h0;
      step();
   endtask

   task automatic nmi_edge();
      nmi = 1'h1;
      repeat (3) step();
      nmi = 1'h0;
   endtask

   // ---------------------------
   // Result watcher
   // ---------------------------
   always @(posedge clk)
   begin
      #1;
      if (svc === 1'h1)
      begin
         if (exp_q.size() == 0)
            check("unexpected service", 0, 1);
         else
         begin
            e = exp_q.pop_front();
            check("vector type", e, vtype);
            check("vector ptr", {e, 2'h0}, vptr);
         end
      end
   end

   initial
   begin
      {rst, nmi, want, slow, mode, hold_req} = 6'h21;
      {bnd, halt_i, lock_p, lock_last, rg_pin, interrupt_return_instr, set_if, clr_if} = 8'h00;
      tbyte = 8'h00;
      seed = 78;
      fail_count = 0;
      num_checks = 0;
      do_reset(1'h1);
      irq(1'h0, 1'h0, 8'h33);
      repeat (4)
      begin
         r = $random(seed);
         irq(1'h1, r[8], r[7:0]);
      end
      // Priority, re-trigger and one-shot latch
      r = $random(seed);
      tbyte = r[7:0];
      want = 1'h1;
      pulse(6);
      nmi_edge();
      exp_q.push_back(`NMI_TYPE);
      pulse(0);
      wait_hi(0, 20);
      check("push", 1, push | u_dut.PUSH_CONTEXT);
      step();
      exp_q.push_back(`NMI_TYPE);
      nmi_edge();
      pulse(0);
      wait_hi(0, 20);
      pulse(0);
      repeat (10) step();
      exp_q.push_back(r[7:0]);
      pulse(6);
      pulse(0);
      wait_hi(0, 30);
      want = 1'h0;
      pulse(5);
      wait_hi(3, 5);
      check("if restored", 1, if_flag);
      // Lock and deferred grant
      pulse(2);
      check("lock on", 0, lock_n);
      pulse(4);
      repeat (4)
      begin
         check("grant held", 0, grant);
         step();
      end
      pulse(3);
      // Lock pin follows the registered prefix state, one clock behind the flag
      step();
      check("lock off", 1, lock_n);
      wait_hi(1, 5);
      // Halt in minimum mode
      pulse(7);
      pulse(1);
      count_ale(n);
      check("halt ale", 1, n);
      hold_req = 1'h1;
      repeat (6) step();
      check("halt in hold", 1, halted);
      hold_req = 1'h0;
      count_ale(n);
      check("halt reissue", 1, n);
      want = 1'h1;
      repeat (8) step();
      check("masked halt", 1, halted);
      want = 1'h0;
      exp_q.push_back(`NMI_TYPE);
      nmi_edge();
      // Halt exit only resumes running; service waits for a boundary
      pulse(0);
      wait_hi(0, 20);
      check("halt exit", 0, halted);
      // Maximum mode
      do_reset(1'h0);
      r = $random(seed);
      irq(1'h1, r[8], r[7:0]);
      pulse(6);
      pulse(1);
      wait_hi(4, 10);
      tbyte = r[15:8];
      exp_q.push_back(r[15:8]);
      want = 1'h1;
      repeat (2) step();
      pulse(0);
      wait_hi(0, 40);
      check("irq halt exit", 0, halted);
      want = 1'h0;
      repeat (4) step();
      check("queue empty", 0, exp_q.size());
      report_and_stop();
   end
endmodule
